/* core/rre_map.svh */
// Register offsets, field positions, encodings and reset values
`ifndef RRE_MAP_SVH
`define RRE_MAP_SVH

// Avalon byte offsets, one aligned word each
`define RRE_OFS_CTRL    8'h00
`define RRE_OFS_OPCODE  8'h04
`define RRE_OFS_STATE   8'h08
`define RRE_OFS_WREG    8'h0c
`define RRE_OFS_STATUS  8'h10
`define RRE_OFS_BSR     8'h14
`define RRE_OFS_SHW     8'h18
`define RRE_OFS_SHST    8'h1c
`define RRE_OFS_SHBSR   8'h20
`define RRE_OFS_PC      8'h24
`define RRE_OFS_STKTOP  8'h28
`define RRE_OFS_STKPTR  8'h2c
`define RRE_OFS_PC_UPPER_LATCH  8'h30
`define RRE_OFS_PC_HIGH_LATCH  8'h34
`define RRE_OFS_FSR2    8'h38
`define RRE_OFS_DADDR   8'h3c
`define RRE_OFS_DDATA   8'h40

// Status flag positions
`define RRE_FLG_C 0
`define RRE_FLG_Z 2
`define RRE_FLG_N 4

// Opcode matching and operand bit positions
`define RRE_RET_MATCH   15'h0009
`define RRE_RLC_MATCH   6'h0d
`define RRE_OP_S        0
`define RRE_OP_A        8
`define RRE_OP_D        9
`define RRE_IDX_LIMIT   8'h5f
`define RRE_ACC_LO_BANK 4'h0
`define RRE_ACC_HI_BANK 4'hf

// Sizes, steps and reset values
`define RRE_STK_DEPTH   5'h1f
`define RRE_PC_STEP     21'h000002
`define RRE_RST_PC      21'h000000
`define RRE_RST_BYTE    8'h00
`define RRE_RST_FLAGS   5'h00
`define RRE_RST_NIB     4'h0

`endif

/* core/rre_pkg.sv */
// Types shared by the return and rotate execution unit
package rre_pkg;

    // Q-phase sequencer, Gray along Q1..Q4
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_Q1   = 3'b001,
        ST_Q2   = 3'b011,
        ST_Q3   = 3'b010,
        ST_Q4   = 3'b110
    } rre_state_t;

    // Decoded instruction class
    typedef enum logic [1:0] {
        OP_NOP = 2'b00,
        OP_RET = 2'b01,
        OP_RLC = 2'b10
    } rre_kind_t;

endpackage : rre_pkg

/* core/rre_exec.sv */
// Return and rotate-left-through-carry execution unit with Avalon slave
`timescale 1ns/1ps
`include "rre_map.svh"

module rre_exec (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Execution status
    output logic             exec_busy
);

    rre_pkg::rre_state_t st_q;
    logic                cyc2_q;
    logic [15:0]         op_q;
    logic [7:0]          w_q;
    logic [4:0]          status_q;
    logic [3:0]          bsr_q;
    logic [7:0]          sh_w_q;
    logic [4:0]          sh_status_q;
    logic [3:0]          sh_bsr_q;
    logic [20:0]         pc_q;
    logic [4:0]          sp_q;
    logic [4:0]          pc_upper_latch_q;
    logic [7:0]          pc_high_latch_q;
    logic                ext_en_q;
    logic [11:0]         fsr2_q;
    logic [11:0]         daddr_q;
    logic [11:0]         ea_q;
    logic [7:0]          opnd_q;
    logic [7:0]          res;
    logic [31:0]         rd_val;
    logic [31:0]         nv;
    logic [20:0]         stk_top;
    logic                wr_fire;
    logic                ret_pop;
    logic                rot_wr;
    logic                instr_end;
    rre_pkg::rre_kind_t  kind;
    logic [20:0]         stk_mem [1:31];
    logic [7:0]          dmem [0:4095];

    // Instruction class from the opcode word
    function automatic rre_pkg::rre_kind_t op_kind(input logic [15:0] op);
        if (op[15:1] == `RRE_RET_MATCH) begin
            return rre_pkg::OP_RET;
        end else if (op[15:10] == `RRE_RLC_MATCH) begin
            return rre_pkg::OP_RLC;
        end
        return rre_pkg::OP_NOP;
    endfunction : op_kind

    // Operand address from access bit, bank select and index mode
    function automatic logic [11:0] eff_addr(input logic [7:0]  f,
                                             input logic        a,
                                             input logic        ext,
                                             input logic [3:0]  bank_select_register,
                                             input logic [11:0] base);
        if (!a && ext && f <= `RRE_IDX_LIMIT) begin
            return base + {`RRE_ACC_LO_BANK, f};
        end else if (!a) begin
            // Low part of access bank is RAM, high part is bank 15
            if (f <= `RRE_IDX_LIMIT) begin
                return {`RRE_ACC_LO_BANK, f};
            end
            return {`RRE_ACC_HI_BANK, f};
        end
        return {bank_select_register, f};
    endfunction : eff_addr

    // Byte-lane merge of a write into the old value
    function automatic logic [31:0] merge32(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge32

    // Strobes shared by several processes
    assign kind      = op_kind(op_q);
    assign wr_fire   = avs_write && !avs_waitrequest;
    assign ret_pop   = st_q == rre_pkg::ST_Q4 && !cyc2_q &&
                       kind == rre_pkg::OP_RET;
    assign rot_wr    = st_q == rre_pkg::ST_Q4 && kind == rre_pkg::OP_RLC;
    assign instr_end = st_q == rre_pkg::ST_Q4 &&
                       !(kind == rre_pkg::OP_RET && !cyc2_q);
    assign stk_top   = (sp_q == 5'h00) ? `RRE_RST_PC : stk_mem[sp_q];
    assign res       = {opnd_q[6:0], status_q[`RRE_FLG_C]};
    assign nv        = merge32(rd_val, avs_writedata, avs_byteenable);

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (avs_address)
            `RRE_OFS_CTRL:   rd_val = {31'h0, ext_en_q};
            `RRE_OFS_OPCODE: rd_val = {16'h0, op_q};
            `RRE_OFS_STATE:  rd_val = {28'h0, cyc2_q, st_q};
            `RRE_OFS_WREG:   rd_val = {24'h0, w_q};
            `RRE_OFS_STATUS: rd_val = {27'h0, status_q};
            `RRE_OFS_BSR:    rd_val = {28'h0, bsr_q};
            `RRE_OFS_SHW:    rd_val = {24'h0, sh_w_q};
            `RRE_OFS_SHST:   rd_val = {27'h0, sh_status_q};
            `RRE_OFS_SHBSR:  rd_val = {28'h0, sh_bsr_q};
            `RRE_OFS_PC:     rd_val = {11'h0, pc_q};
            `RRE_OFS_STKTOP: rd_val = {11'h0, stk_top};
            `RRE_OFS_STKPTR: rd_val = {27'h0, sp_q};
            `RRE_OFS_PC_UPPER_LATCH: rd_val = {27'h0, pc_upper_latch_q};
            `RRE_OFS_PC_HIGH_LATCH: rd_val = {24'h0, pc_high_latch_q};
            `RRE_OFS_FSR2:   rd_val = {20'h0, fsr2_q};
            `RRE_OFS_DADDR:  rd_val = {20'h0, daddr_q};
            `RRE_OFS_DDATA:  rd_val = {24'h0, dmem[daddr_q]};
            default:         rd_val = 32'h0;
        endcase
    end

    // Bus handshake; writes wait for idle so the core owns its registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read ||
                     (avs_write && st_q == rre_pkg::ST_IDLE)) begin
            avs_waitrequest <= 1'b0;
            if (avs_read) begin
                avs_readdata <= rd_val;
            end
        end
    end

    // Q-phase sequencer; an opcode write starts an instruction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q   <= rre_pkg::ST_IDLE;
            cyc2_q <= 1'b0;
            op_q   <= 16'h0;
        end else begin
            case (st_q)
                rre_pkg::ST_IDLE: begin
                    if (wr_fire && avs_address == `RRE_OFS_OPCODE) begin
                        op_q   <= nv[15:0];
                        cyc2_q <= 1'b0;
                        st_q   <= rre_pkg::ST_Q1;
                    end
                end
                rre_pkg::ST_Q1: st_q <= rre_pkg::ST_Q2;
                rre_pkg::ST_Q2: st_q <= rre_pkg::ST_Q3;
                rre_pkg::ST_Q3: st_q <= rre_pkg::ST_Q4;
                rre_pkg::ST_Q4: begin
                    if (ret_pop) begin
                        cyc2_q <= 1'b1;
                        st_q   <= rre_pkg::ST_Q1;
                    end else begin
                        cyc2_q <= 1'b0;
                        st_q   <= rre_pkg::ST_IDLE;
                    end
                end
                default: st_q <= rre_pkg::ST_IDLE;
            endcase
        end
    end

    // Busy flag for software polling
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            exec_busy <= 1'b0;
        end else begin
            exec_busy <= (st_q == rre_pkg::ST_IDLE) ?
                         (wr_fire && avs_address == `RRE_OFS_OPCODE) :
                         !instr_end;
        end
    end

    // Operand fetch in Q2; address is latched for the Q4 write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ea_q   <= 12'h0;
            opnd_q <= `RRE_RST_BYTE;
        end else if (st_q == rre_pkg::ST_Q2 && kind == rre_pkg::OP_RLC) begin
            ea_q   <= eff_addr(op_q[7:0], op_q[`RRE_OP_A], ext_en_q,
                               bsr_q, fsr2_q);
            opnd_q <= dmem[eff_addr(op_q[7:0], op_q[`RRE_OP_A], ext_en_q,
                                    bsr_q, fsr2_q)];
        end
    end

    // Working, status and bank select registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_q      <= `RRE_RST_BYTE;
            status_q <= `RRE_RST_FLAGS;
            bsr_q    <= `RRE_RST_NIB;
        end else if (ret_pop) begin
            // Without the restore bit nothing is touched here
            if (op_q[`RRE_OP_S]) begin
                w_q      <= sh_w_q;
                status_q <= sh_status_q;
                bsr_q    <= sh_bsr_q;
            end
        end else if (rot_wr) begin
            if (!op_q[`RRE_OP_D]) begin
                w_q <= res;
            end
            status_q[`RRE_FLG_C] <= opnd_q[7];
            status_q[`RRE_FLG_Z] <= res == 8'h00;
            status_q[`RRE_FLG_N] <= res[7];
        end else if (wr_fire) begin
            case (avs_address)
                `RRE_OFS_WREG:   w_q      <= nv[7:0];
                `RRE_OFS_STATUS: status_q <= nv[4:0];
                `RRE_OFS_BSR:    bsr_q    <= nv[3:0];
                default: ;
            endcase
        end
    end

    // Shadow copies, loaded by software only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_w_q      <= `RRE_RST_BYTE;
            sh_status_q <= `RRE_RST_FLAGS;
            sh_bsr_q    <= `RRE_RST_NIB;
        end else if (wr_fire) begin
            case (avs_address)
                `RRE_OFS_SHW:   sh_w_q      <= nv[7:0];
                `RRE_OFS_SHST:  sh_status_q <= nv[4:0];
                `RRE_OFS_SHBSR: sh_bsr_q    <= nv[3:0];
                default: ;
            endcase
        end
    end

    // Program counter and stack pointer; empty stack pops zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc_q <= `RRE_RST_PC;
            sp_q <= 5'h00;
        end else if (ret_pop) begin
            pc_q <= stk_top;
            if (sp_q != 5'h00) begin
                sp_q <= sp_q - 5'h01;
            end
        end else if (instr_end && kind != rre_pkg::OP_RET) begin
            // Second return cycle must leave the popped PC alone
            pc_q <= pc_q + `RRE_PC_STEP;
        end else if (wr_fire) begin
            case (avs_address)
                `RRE_OFS_PC: pc_q <= nv[20:0];
                // Push saturates at full depth, overwriting the top
                `RRE_OFS_STKTOP: begin
                    if (sp_q != `RRE_STK_DEPTH) begin
                        sp_q <= sp_q + 5'h01;
                    end
                end
                `RRE_OFS_STKPTR: sp_q <= nv[4:0];
                default: ;
            endcase
        end
    end

    // Stack storage, written by software pushes
    always_ff @(posedge clk) begin
        if (wr_fire && avs_address == `RRE_OFS_STKTOP) begin
            if (sp_q == `RRE_STK_DEPTH) begin
                stk_mem[sp_q] <= nv[20:0];
            end else begin
                stk_mem[sp_q + 5'h01] <= nv[20:0];
            end
        end
    end

    // PC latches: software only, a return leaves them alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc_upper_latch_q <= 5'h00;
            pc_high_latch_q <= `RRE_RST_BYTE;
        end else if (wr_fire && avs_address == `RRE_OFS_PC_UPPER_LATCH) begin
            pc_upper_latch_q <= nv[4:0];
        end else if (wr_fire && avs_address == `RRE_OFS_PC_HIGH_LATCH) begin
            pc_high_latch_q <= nv[7:0];
        end
    end

    // Mode and addressing controls
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_en_q <= 1'b0;
            fsr2_q   <= 12'h0;
            daddr_q  <= 12'h0;
        end else if (wr_fire) begin
            case (avs_address)
                `RRE_OFS_CTRL:  ext_en_q <= nv[0];
                `RRE_OFS_FSR2:  fsr2_q   <= nv[11:0];
                `RRE_OFS_DADDR: daddr_q  <= nv[11:0];
                default: ;
            endcase
        end
    end

    // Data memory; writes are exclusive since the bus waits while busy
    always_ff @(posedge clk) begin
        if (rot_wr && op_q[`RRE_OP_D]) begin
            dmem[ea_q] <= res;
        end else if (wr_fire && avs_address == `RRE_OFS_DDATA) begin
            dmem[daddr_q] <= nv[7:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_ret_pop_pc: assert property (
        ret_pop |=> pc_q == $past(stk_top))
        else $error("return did not load stack top into pc");
    chk_ret_two_cyc: assert property (
        (st_q == rre_pkg::ST_Q1 && !cyc2_q && kind == rre_pkg::OP_RET)
        |-> ##7 (st_q == rre_pkg::ST_Q4 && cyc2_q)
        ##1 st_q == rre_pkg::ST_IDLE)
        else $error("return did not take two cycles");
    chk_ret_restore: assert property (
        ret_pop && op_q[`RRE_OP_S] |=> w_q == $past(sh_w_q) &&
        status_q == $past(sh_status_q) && bsr_q == $past(sh_bsr_q))
        else $error("shadow restore missing");
    chk_ret_keep: assert property (
        ret_pop && !op_q[`RRE_OP_S] |=>
        $stable(w_q) && $stable(status_q) && $stable(bsr_q))
        else $error("registers changed without restore");
    chk_ret_latches: assert property (
        kind == rre_pkg::OP_RET && st_q != rre_pkg::ST_IDLE |=>
        $stable(pc_upper_latch_q) && $stable(pc_high_latch_q))
        else $error("pc latch changed by return");
    chk_rot_flags: assert property (
        rot_wr |=> status_q[`RRE_FLG_C] == $past(opnd_q[7]) &&
        status_q[`RRE_FLG_N] == $past(res[7]) &&
        status_q[`RRE_FLG_Z] == ($past(res) == 8'h00))
        else $error("rotate flags wrong");
    chk_rot_to_w: assert property (
        rot_wr && !op_q[`RRE_OP_D] |=> w_q == $past(res) &&
        dmem[$past(ea_q)] == $past(opnd_q))
        else $error("rotate to w wrong");
    chk_rot_to_mem: assert property (
        rot_wr && op_q[`RRE_OP_D] |=> dmem[$past(ea_q)] == $past(res))
        else $error("rotate write-back wrong");
    chk_acc_bank: assert property (
        st_q == rre_pkg::ST_Q2 && kind == rre_pkg::OP_RLC &&
        !op_q[`RRE_OP_A] && !ext_en_q |=>
        ea_q[11:8] == (op_q[7:0] <= `RRE_IDX_LIMIT ?
                       `RRE_ACC_LO_BANK : `RRE_ACC_HI_BANK))
        else $error("access bank address wrong");
    chk_bsr_bank: assert property (
        st_q == rre_pkg::ST_Q2 && kind == rre_pkg::OP_RLC &&
        op_q[`RRE_OP_A] |=> ea_q == {$past(bsr_q), op_q[7:0]})
        else $error("bank select address wrong");
    chk_idx_mode: assert property (
        st_q == rre_pkg::ST_Q2 && kind == rre_pkg::OP_RLC &&
        !op_q[`RRE_OP_A] && ext_en_q && op_q[7:0] <= `RRE_IDX_LIMIT |=>
        ea_q == $past(fsr2_q) + {4'h0, op_q[7:0]})
        else $error("indexed address wrong");
    chk_rot_one_cyc: assert property (
        (st_q == rre_pkg::ST_Q1 && kind == rre_pkg::OP_RLC)
        |-> ##3 rot_wr ##1 st_q == rre_pkg::ST_IDLE)
        else $error("rotate not one cycle");

    cov_ret_restore: cover property (ret_pop && op_q[`RRE_OP_S]);
    cov_rot_to_w: cover property (rot_wr && !op_q[`RRE_OP_D]);
    cov_rot_indexed: cover property (rot_wr && ext_en_q &&
                                     !op_q[`RRE_OP_A]);
    cov_write_stall: cover property (avs_write && exec_busy);

endmodule : rre_exec

/* sim/tb_return_and_rotate_exec.sv */
// Self-checking bench for the return and rotate execution unit
`timescale 1ns/1ps
`include "rre_map.svh"

module tb_return_and_rotate_exec;

    logic        clk;
    logic        sys_rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        exec_busy;
    int          n_mismatch;
    int          cmp_count;
    int          busy_cnt;
    // Reference model state
    int          w, st, b, shw, shst, shb, plu, plh, pcv, s0, s1;
    int          d, a, ext, f, fsr, v, addr, res, op;

    rre_exec rre_exec_i (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .exec_busy       (exec_busy)
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    // Busy length, sampled mid-cycle where it is settled
    always @(negedge clk) begin
        if (exec_busy === 1'b1) busy_cnt++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address   <= ad;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) n_mismatch++;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] ad, input int wd);
        logic [31:0] x;
        bus(1'b1, ad, wd, x);
    endtask : wr

    task automatic rd_chk(input logic [7:0] ad, input int exp);
        logic [31:0] x;
        bus(1'b0, ad, 32'h0, x);
        check(x, exp);
    endtask : rd_chk

    // Start an instruction and wait, bounded, for it to finish
    task automatic run_op(input int opc);
        int n;
        n = 0;
        busy_cnt = 0;
        wr(`RRE_OFS_OPCODE, opc);
        @(posedge clk);
        while (exec_busy !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) n_mismatch++;
    endtask : run_op

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog, far beyond the expected two thousand or so cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        n_mismatch = 0;
        cmp_count = 0;
        busy_cnt = 0;
        void'($urandom(61218));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);

        // Reset values, then unmapped places read zero and ignore writes
        for (int k = 0; k < 16; k++) rd_chk(8'(k * 4), 0);
        wr(8'h80, $urandom);
        rd_chk(8'h80, 0);
        rd_chk(8'hfc, 0);
        $display("reset and map test done");

        // Return: pop twice, then once from an empty stack
        w = $urandom % 256; st = $urandom % 32; b = $urandom % 16;
        shw = $urandom % 256; shst = $urandom % 32; shb = $urandom % 16;
        plu = $urandom % 32; plh = $urandom % 256;
        s0 = $urandom & 32'h1ffffe; s1 = $urandom & 32'h1ffffe;
        wr(`RRE_OFS_WREG, w); wr(`RRE_OFS_STATUS, st); wr(`RRE_OFS_BSR, b);
        wr(`RRE_OFS_SHW, shw); wr(`RRE_OFS_SHST, shst);
        wr(`RRE_OFS_SHBSR, shb);
        wr(`RRE_OFS_PC_UPPER_LATCH, plu); wr(`RRE_OFS_PC_HIGH_LATCH, plh);
        wr(`RRE_OFS_STKTOP, s0); wr(`RRE_OFS_STKTOP, s1);
        for (int k = 0; k < 3; k++) begin
            run_op(16'h0012 | (k == 1));
            if (k == 1) begin
                w = shw; st = shst; b = shb;
            end
            pcv = (k == 0) ? s1 : (k == 1) ? s0 : 0;
            check(32'(busy_cnt), 8);
            rd_chk(`RRE_OFS_PC, pcv);
            rd_chk(`RRE_OFS_STKPTR, (k == 0) ? 1 : 0);
            rd_chk(`RRE_OFS_WREG, w);
            rd_chk(`RRE_OFS_STATUS, st);
            rd_chk(`RRE_OFS_BSR, b);
            rd_chk(`RRE_OFS_PC_UPPER_LATCH, plu);
            rd_chk(`RRE_OFS_PC_HIGH_LATCH, plh);
        end
        $display("return test done");

        // Rotate: access-bank split and indexed boundary first, then random
        for (int i = 0; i < 40; i++) begin
            d = $urandom % 2; a = $urandom % 2; ext = $urandom % 2;
            f = $urandom % 256;
            if (i < 4) begin
                a = 0; ext = i / 2; f = (i % 2) ? 8'h5f : 8'h60;
            end
            b = $urandom % 16; fsr = $urandom % 4096;
            st = $urandom % 32; v = $urandom % 256; w = $urandom % 256;
            if (a) addr = b * 256 + f;
            else if (ext && f <= 8'h5f) addr = (fsr + f) % 4096;
            else addr = (f <= 8'h5f) ? f : 12'hf00 + f;
            wr(`RRE_OFS_CTRL, ext); wr(`RRE_OFS_BSR, b);
            wr(`RRE_OFS_FSR2, fsr); wr(`RRE_OFS_STATUS, st);
            wr(`RRE_OFS_WREG, w); wr(`RRE_OFS_DADDR, addr);
            wr(`RRE_OFS_DDATA, v);
            op = (6'h0d << 10) | (d << `RRE_OP_D) | (a << `RRE_OP_A) | f;
            run_op(op);
            res = ((v << 1) | (st & 1)) & 8'hff;
            st = (st & ~32'h15) | ((v >> 7) << `RRE_FLG_C)
                 | ((res >> 7) << `RRE_FLG_N) | ((res == 0) << `RRE_FLG_Z);
            if (d) v = res;
            else w = res;
            pcv = (pcv + 2) % 32'h200000;
            check(32'(busy_cnt), 4);
            rd_chk(`RRE_OFS_STATUS, st);
            rd_chk(`RRE_OFS_WREG, w);
            rd_chk(`RRE_OFS_DDATA, v);
            rd_chk(`RRE_OFS_PC, pcv);
        end
        $display("rotate test done");
        complete_run();
    end

endmodule : tb_return_and_rotate_exec
